// file: hdl/dual_bus_pkg.sv
// Shared constants and types for the dual processor expansion bus link.
// Assumes one clock for both processors and the glue logic.
package dual_bus_pkg;

  localparam int unsigned DATA_W             = 32;
  localparam int unsigned PAGE_W             = 4;
  localparam int unsigned SLAVE_WAIT_DEFAULT = 2;

  // Reset-time strap layout on the shared data lines
  localparam int unsigned SPACE_TYPE_LSB = 16;
  localparam int unsigned SPACE_TYPE_W   = 3;
  localparam int unsigned RWPOL_BIT      = 12;
  localparam int unsigned HOST_MODE_BIT  = 11;
  localparam int unsigned ARB_EN_BIT     = 10;

  localparam logic [SPACE_TYPE_W-1:0] SPACE_TYPE_ASYNC = 3'h2;
  localparam logic                    HOST_MODE_ASYNC  = 1'h0;
  localparam logic                    RWPOL_READ_LOW   = 1'h0;
  localparam logic                    ARB_ON           = 1'h1;
  localparam logic                    ARB_OFF          = 1'h0;

  // Pull resistor pattern without the arbiter bit
  localparam logic [DATA_W-1:0] STRAP_BASE   = 32'h2222_0105;
  localparam logic [DATA_W-1:0] FIRST_STRAP  = STRAP_BASE | (32'h1 << ARB_EN_BIT);
  localparam logic [DATA_W-1:0] SECOND_STRAP = STRAP_BASE;

  localparam logic [PAGE_W-1:0] FIRST_PAGE_DEFAULT  = 4'h1;
  localparam logic [PAGE_W-1:0] SECOND_PAGE_DEFAULT = 4'h2;

  typedef enum logic [2:0] {M_IDLE, M_REQ, M_SETUP, M_STROBE, M_HOLD} master_e;

endpackage

// file: hdl/exp_bus_if.sv
// Pins of one processor's expansion port as seen by the glue logic.
// Assumes two instances, one per processor, both joined to one glue block.
interface exp_bus_if;
  import dual_bus_pkg::*;

  logic              space0_chip_enable_n;
  logic              master_read_strobe_n;
  logic              master_write_strobe_n;
  logic              master_output_enable_n;
  logic              master_addr_bit2;
  logic [PAGE_W-1:0] master_addr_page;
  logic [DATA_W-1:0] data_out;
  logic              data_oe;
  logic              ready_out;
  logic              ready_oe;
  logic              hold_req;
  logic              bus_grant_ack_pin;
  logic              switch_close;
  logic              slave_host_select_n;
  logic              slave_direction_in;
  logic              slave_reg_select;
  logic              access_ready;
  logic [DATA_W-1:0] shared_data_lines;
  logic              hold_in;
  logic              bus_grant_ack;

  modport proc (
    output space0_chip_enable_n, master_read_strobe_n, master_write_strobe_n,
    output master_output_enable_n, master_addr_bit2, master_addr_page,
    output data_out, data_oe, ready_out, ready_oe, hold_req, bus_grant_ack_pin,
    output switch_close,
    input  slave_host_select_n, slave_direction_in, slave_reg_select,
    input  access_ready, shared_data_lines, hold_in, bus_grant_ack
  );

  modport glue (
    input  space0_chip_enable_n, master_read_strobe_n, master_write_strobe_n,
    input  master_output_enable_n, master_addr_bit2, master_addr_page,
    input  data_out, data_oe, ready_out, ready_oe, hold_req, bus_grant_ack_pin,
    input  switch_close,
    output slave_host_select_n, slave_direction_in, slave_reg_select,
    output access_ready, shared_data_lines, hold_in, bus_grant_ack
  );
endinterface

// file: hdl/proc_end.sv
// Expansion port of one processor: async master port plus async host slave.
// Assumes the glue logic forms its select, direction and ready paths.
module proc_end #(
  parameter logic        IS_FIRST   = 1'h1,
  parameter int unsigned SLAVE_WAIT = dual_bus_pkg::SLAVE_WAIT_DEFAULT
) (
  input  wire logic                            clk_i,
  input  wire logic                            reset_i,
  exp_bus_if.proc                              bus,
  input  wire logic                            req_valid_i,
  input  wire logic                            req_write_i,
  input  wire logic                            req_reg_sel_i,
  input  wire logic [dual_bus_pkg::PAGE_W-1:0] req_page_i,
  input  wire logic [dual_bus_pkg::DATA_W-1:0] req_wdata_i,
  output logic                                 req_ready_o,
  output logic                                 done_o,
  output logic      [dual_bus_pkg::DATA_W-1:0] rdata_o,
  output logic                                 slave_wr_o,
  output logic      [dual_bus_pkg::DATA_W-1:0] slave_wr_data_o,
  output logic      [dual_bus_pkg::DATA_W-1:0] slave_addr_o,
  input  wire logic [dual_bus_pkg::DATA_W-1:0] slave_rdata_i,
  input  wire logic                            switch_close_i,
  output logic                                 cfg_arbiter_o,
  output logic                                 cfg_ok_o
);
  import dual_bus_pkg::*;

  localparam int unsigned WAIT_W = $clog2(SLAVE_WAIT + 1) + 1;

  typedef struct packed {
    master_e                 mst;
    logic                    grant;
    logic                    mdone;
    logic                    mwrite;
    logic                    mregsel;
    logic [PAGE_W-1:0]       mpage;
    logic [DATA_W-1:0]       mwdata;
    logic [DATA_W-1:0]       mrdata;
    logic                    cfg_arb;
    logic                    cfg_rwpol;
    logic                    cfg_host_mode;
    logic [SPACE_TYPE_W-1:0] cfg_space_type;
    logic                    served;
    logic [WAIT_W-1:0]       wcnt;
    logic [DATA_W-1:0]       host_addr;
    logic [DATA_W-1:0]       sdata;
    logic                    swr;
    logic [DATA_W-1:0]       swdata;
    logic                    gpio;
  } state_s;

  state_s s;
  state_s next_s;
  logic   active;
  logic   cfg_ok;
  logic   slave_sel;
  logic   slave_read;

  assign active     = (s.mst == M_SETUP) || (s.mst == M_STROBE) || (s.mst == M_HOLD);
  assign cfg_ok     = (s.cfg_space_type == SPACE_TYPE_ASYNC) &&
                      (s.cfg_host_mode == HOST_MODE_ASYNC);
  assign slave_sel  = !bus.slave_host_select_n && !active && cfg_ok;
  assign slave_read = (bus.slave_direction_in == s.cfg_rwpol);

  always_comb begin
    next_s       = s;
    next_s.mdone = 1'h0;
    next_s.swr   = 1'h0;
    next_s.gpio  = switch_close_i;
    if (IS_FIRST) begin
      next_s.grant = bus.hold_in && s.cfg_arb && !active;
    end else begin
      next_s.grant = 1'h0;
    end
    unique case (s.mst)
      M_IDLE: begin
        if (req_valid_i && cfg_ok) begin
          next_s.mst     = M_REQ;
          next_s.mwrite  = req_write_i;
          next_s.mregsel = req_reg_sel_i;
          next_s.mpage   = req_page_i;
          next_s.mwdata  = req_wdata_i;
        end
      end
      M_REQ: begin
        if (IS_FIRST ? (!s.grant && !bus.hold_in) : bus.bus_grant_ack) begin
          next_s.mst = M_SETUP;
        end
      end
      M_SETUP: begin
        next_s.mst = M_STROBE;
      end
      M_STROBE: begin
        if (bus.access_ready) begin
          if (!s.mwrite) begin
            next_s.mrdata = bus.shared_data_lines;
          end
          next_s.mst = M_HOLD;
        end
      end
      M_HOLD: begin
        next_s.mst   = M_IDLE;
        next_s.mdone = 1'h1;
      end
    endcase
    if (slave_sel && !s.served) begin
      if (s.wcnt == WAIT_W'(SLAVE_WAIT)) begin
        next_s.served = 1'h1;
        if (slave_read) begin
          next_s.sdata = bus.slave_reg_select ? slave_rdata_i : s.host_addr;
        end else if (bus.slave_reg_select) begin
          next_s.swr    = 1'h1;
          next_s.swdata = bus.shared_data_lines;
        end else begin
          next_s.host_addr = bus.shared_data_lines;
        end
      end else begin
        next_s.wcnt = s.wcnt + WAIT_W'(1);
      end
    end
    if (!slave_sel) begin
      next_s.served = 1'h0;
      next_s.wcnt   = '0;
    end
    if (reset_i) begin
      next_s                = '0;
      next_s.mst            = M_IDLE;
      next_s.cfg_arb        = bus.shared_data_lines[ARB_EN_BIT];
      next_s.cfg_rwpol      = bus.shared_data_lines[RWPOL_BIT];
      next_s.cfg_host_mode  = bus.shared_data_lines[HOST_MODE_BIT];
      next_s.cfg_space_type = bus.shared_data_lines[SPACE_TYPE_LSB +: SPACE_TYPE_W];
    end
  end

  always_ff @(posedge clk_i) begin
    s <= next_s;
  end

  assign bus.space0_chip_enable_n   = !active;
  assign bus.master_read_strobe_n   = !((s.mst == M_STROBE) && !s.mwrite);
  assign bus.master_write_strobe_n  = !((s.mst == M_STROBE) && s.mwrite);
  assign bus.master_output_enable_n = !(active && !s.mwrite);
  assign bus.master_addr_bit2       = active && s.mregsel;
  assign bus.master_addr_page       = s.mpage;
  assign bus.data_out               = active ? s.mwdata : s.sdata;
  assign bus.data_oe                = (active && s.mwrite) || (s.served && slave_read && slave_sel);
  assign bus.ready_out              = s.served;
  assign bus.ready_oe               = !active;
  assign bus.hold_req               = !IS_FIRST && (s.mst != M_IDLE);
  assign bus.bus_grant_ack_pin      = s.grant;
  assign bus.switch_close           = s.gpio;

  assign req_ready_o     = (s.mst == M_IDLE) && cfg_ok;
  assign done_o          = s.mdone;
  assign rdata_o         = s.mrdata;
  assign slave_wr_o      = s.swr;
  assign slave_wr_data_o = s.swdata;
  assign slave_addr_o    = s.host_addr;
  assign cfg_arbiter_o   = s.cfg_arb;
  assign cfg_ok_o        = cfg_ok && (s.cfg_rwpol == RWPOL_READ_LOW);
endmodule

// file: hdl/dual_bus_glue.sv
// Glue logic joining the expansion ports of two processors.
// Assumes one exp_bus_if per processor and a shared clock.
// Functional notes
// - Slave select from space enable and strobes
// - Slave direction driven from output enable
// - Slave strapped so direction low reads
// - Address bit two drives register select
// - Slave ready holds master access off
// - Data lines split in reset, switch closes
// - First arbiter enabled, second disabled
// - Second holds, first acknowledges the grant
// - Select falls after direction and register select
// - Select also decodes the master address page
// - Master controls driven always, direction when master
// - Output enable tristated unless master transacting
// - Ready output driven whenever in slave mode
// - Ready isolated while both are slaves
// - Enable low while matching processor masters
// - Both enables off when nobody masters
// - Enables from space enable and grant
// - Space zero typed as async memory
// - Host port strapped to async mode
module dual_bus_glue #(
  parameter logic [dual_bus_pkg::DATA_W-1:0] FIRST_STRAP  = dual_bus_pkg::FIRST_STRAP,
  parameter logic [dual_bus_pkg::DATA_W-1:0] SECOND_STRAP = dual_bus_pkg::SECOND_STRAP,
  parameter logic [dual_bus_pkg::PAGE_W-1:0] FIRST_PAGE   = dual_bus_pkg::FIRST_PAGE_DEFAULT,
  parameter logic [dual_bus_pkg::PAGE_W-1:0] SECOND_PAGE  = dual_bus_pkg::SECOND_PAGE_DEFAULT,
  parameter logic                            DECODE_EN    = 1'h1
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic first_in_reset_i,
  input  wire logic second_in_reset_i,
  exp_bus_if.glue   first_bus,
  exp_bus_if.glue   second_bus,
  output logic      first_master_buffer_en_n_o,
  output logic      second_master_buffer_en_n_o,
  output logic      switch_closed_o,
  output logic      first_select_n_o,
  output logic      second_select_n_o
);
  import dual_bus_pkg::*;

  typedef struct packed {
    logic switch_closed;
    logic first_sel_n;
    logic second_sel_n;
  } state_s;

  state_s s;
  state_s next_s;
  logic   any_reset;
  logic   first_en;
  logic   second_en;
  logic   first_oe_buf_n;
  logic   second_oe_buf_n;
  logic   first_wants;
  logic   second_wants;

  function automatic logic select_wanted(input logic              en,
                                         input logic              re_n,
                                         input logic              we_n,
                                         input logic [PAGE_W-1:0] page,
                                         input logic [PAGE_W-1:0] target);
    select_wanted = en && (!re_n || !we_n) && (!DECODE_EN || (page == target));
  endfunction

  function automatic logic ready_seen(input logic en,
                                      input logic rdy,
                                      input logic rdy_oe);
    ready_seen = en ? (rdy_oe ? rdy : 1'h1) : 1'h1;
  endfunction

  function automatic logic [DATA_W-1:0] data_seen(input logic [DATA_W-1:0] strap,
                                                  input logic [DATA_W-1:0] other,
                                                  input logic              other_oe,
                                                  input logic              closed);
    data_seen = (closed && other_oe) ? other : strap;
  endfunction

  assign any_reset = reset_i || first_in_reset_i || second_in_reset_i;

  assign first_en  = !first_bus.space0_chip_enable_n && !first_bus.bus_grant_ack_pin &&
                     !any_reset;
  assign second_en = !second_bus.space0_chip_enable_n && first_bus.bus_grant_ack_pin &&
                     !any_reset;

  assign first_oe_buf_n  = first_en ? first_bus.master_output_enable_n : 1'h1;
  assign second_oe_buf_n = second_en ? second_bus.master_output_enable_n : 1'h1;

  assign first_wants  = select_wanted(first_en, first_bus.master_read_strobe_n,
                                      first_bus.master_write_strobe_n,
                                      first_bus.master_addr_page, SECOND_PAGE);
  assign second_wants = select_wanted(second_en, second_bus.master_read_strobe_n,
                                      second_bus.master_write_strobe_n,
                                      second_bus.master_addr_page, FIRST_PAGE);

  always_comb begin
    next_s = s;
    next_s.second_sel_n = !first_wants;
    next_s.first_sel_n  = !second_wants;
    if (first_bus.switch_close || second_bus.switch_close) begin
      next_s.switch_closed = 1'h1;
    end
    if (any_reset) begin
      next_s.switch_closed = 1'h0;
      next_s.first_sel_n   = 1'h1;
      next_s.second_sel_n  = 1'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    s <= next_s;
  end

  assign second_bus.slave_direction_in = first_oe_buf_n;
  assign first_bus.slave_direction_in  = second_oe_buf_n;

  // Address bit two to register select
  assign second_bus.slave_reg_select = first_en && first_bus.master_addr_bit2;
  assign first_bus.slave_reg_select  = second_en && second_bus.master_addr_bit2;

  assign second_bus.slave_host_select_n = s.second_sel_n;
  assign first_bus.slave_host_select_n  = s.first_sel_n;

  assign first_bus.access_ready  = ready_seen(first_en, second_bus.ready_out,
                                              second_bus.ready_oe);
  assign second_bus.access_ready = ready_seen(second_en, first_bus.ready_out,
                                              first_bus.ready_oe);

  assign first_bus.hold_in        = second_bus.hold_req;
  assign second_bus.hold_in       = 1'h0;
  assign second_bus.bus_grant_ack = first_bus.bus_grant_ack_pin;
  assign first_bus.bus_grant_ack  = 1'h0;

  assign first_bus.shared_data_lines  = data_seen(FIRST_STRAP, second_bus.data_out,
                                                  second_bus.data_oe, s.switch_closed);
  assign second_bus.shared_data_lines = data_seen(SECOND_STRAP, first_bus.data_out,
                                                  first_bus.data_oe, s.switch_closed);

  assign first_master_buffer_en_n_o  = !first_en;
  assign second_master_buffer_en_n_o = !second_en;
  assign switch_closed_o             = s.switch_closed;
  assign first_select_n_o            = s.first_sel_n;
  assign second_select_n_o           = s.second_sel_n;
endmodule

// file: tb/dual_bus_checker.sv
// Concurrent checks on the glue between the two expansion ports.
// Assumes the bench hands over the interface signals of both processors.
module dual_bus_checker (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic first_in_reset_i,
  input wire logic second_in_reset_i,
  input wire logic first_master_buffer_en_n_o,
  input wire logic second_master_buffer_en_n_o,
  input wire logic switch_closed_o,
  input wire logic first_space0_chip_enable_n,
  input wire logic first_master_read_strobe_n,
  input wire logic first_master_write_strobe_n,
  input wire logic first_master_output_enable_n,
  input wire logic first_master_addr_bit2,
  input wire logic first_bus_grant_ack_pin,
  input wire logic first_access_ready,
  input wire logic second_space0_chip_enable_n,
  input wire logic second_hold_req,
  input wire logic second_bus_grant_ack,
  input wire logic second_slave_host_select_n,
  input wire logic second_slave_direction_in,
  input wire logic second_slave_reg_select,
  input wire logic second_access_ready,
  input wire logic first_page_hit
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  property p_en1;
    first_master_buffer_en_n_o == (first_space0_chip_enable_n | first_bus_grant_ack_pin
      | first_in_reset_i | second_in_reset_i);
  endproperty
  a_en1: assert property (p_en1)
    else $error("first buffer enable wrong");
  property p_en2;
    second_master_buffer_en_n_o == (second_space0_chip_enable_n | !first_bus_grant_ack_pin
      | first_in_reset_i | second_in_reset_i);
  endproperty
  a_en2: assert property (p_en2)
    else $error("second buffer enable wrong");
  property p_excl;
    first_master_buffer_en_n_o || second_master_buffer_en_n_o;
  endproperty
  a_excl: assert property (p_excl)
    else $error("both buffer enables active");
  property p_sel;
    !second_slave_host_select_n |-> !$past(first_space0_chip_enable_n)
      && !($past(first_master_read_strobe_n) && $past(first_master_write_strobe_n));
  endproperty
  a_sel: assert property (p_sel)
    else $error("slave select without space enable and strobe");
  property p_setup;
    $fell(second_slave_host_select_n) |->
      $stable(second_slave_direction_in) && $stable(second_slave_reg_select);
  endproperty
  a_setup: assert property (p_setup)
    else $error("select fell with direction or register select moving");
  property p_dir;
    !first_master_buffer_en_n_o |-> second_slave_direction_in == first_master_output_enable_n;
  endproperty
  a_dir: assert property (p_dir)
    else $error("slave direction not from output enable");
  property p_cntl;
    !first_master_buffer_en_n_o |-> second_slave_reg_select == first_master_addr_bit2;
  endproperty
  a_cntl: assert property (p_cntl)
    else $error("register select not from address bit two");
  property p_iso;
    first_master_buffer_en_n_o && second_master_buffer_en_n_o |->
      first_access_ready && second_access_ready;
  endproperty
  a_iso: assert property (p_iso)
    else $error("ready not isolated with no master");
  property p_grant;
    $rose(second_hold_req) |-> ##[0:40] second_bus_grant_ack;
  endproperty
  a_grant: assert property (p_grant)
    else $error("hold not acknowledged in time");
  property p_sw;
    first_in_reset_i || second_in_reset_i |=> !switch_closed_o;
  endproperty
  a_sw: assert property (p_sw)
    else $error("switch closed during reset");
  property p_oe_off;
    first_master_buffer_en_n_o |-> second_slave_direction_in;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("output enable not released while not master");
  property p_page;
    !second_slave_host_select_n |-> $past(first_page_hit);
  endproperty
  a_page: assert property (p_page)
    else $error("slave selected outside its page");
endmodule

// file: tb/tb.sv
// Bench: two processor ends joined by the glue, driven from their user sides.
// Assumes one 25 MHz clock and synchronous active high reset.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dual_bus_pkg::*;

  logic              clk_i, reset_i, first_in_reset_i, second_in_reset_i;
  logic              first_master_buffer_en_n_o, second_master_buffer_en_n_o;
  logic              switch_closed_o, first_select_n_o, second_select_n_o;
  logic              req_valid [2], req_write [2], req_reg_sel [2], req_ready [2];
  logic              done [2], slave_wr [2], switch_close [2], cfg_arb [2], cfg_ok [2];
  logic [PAGE_W-1:0] req_page [2];
  logic [DATA_W-1:0] req_wdata [2], rdata [2], slave_wr_data [2], slave_addr [2];
  logic [DATA_W-1:0] slave_rdata [2], got_wr [2], rd;
  logic              saw_grant;
  int                bad_count, samples_checked;

  exp_bus_if bus_if [2] ();
  for (genvar p = 0; p < 2; p++) begin : g_end
    proc_end #(.IS_FIRST(p == 0)) proc_end_i (.clk_i, .reset_i, .bus(bus_if[p]),
      .req_valid_i(req_valid[p]), .req_write_i(req_write[p]), .req_reg_sel_i(req_reg_sel[p]),
      .req_page_i(req_page[p]), .req_wdata_i(req_wdata[p]), .req_ready_o(req_ready[p]),
      .done_o(done[p]), .rdata_o(rdata[p]), .slave_wr_o(slave_wr[p]),
      .slave_wr_data_o(slave_wr_data[p]), .slave_addr_o(slave_addr[p]),
      .slave_rdata_i(slave_rdata[p]), .switch_close_i(switch_close[p]),
      .cfg_arbiter_o(cfg_arb[p]), .cfg_ok_o(cfg_ok[p]));
  end
  dual_bus_glue dual_bus_glue_i (.clk_i, .reset_i, .first_in_reset_i, .second_in_reset_i,
    .first_bus(bus_if[0]), .second_bus(bus_if[1]), .first_master_buffer_en_n_o,
    .second_master_buffer_en_n_o, .switch_closed_o, .first_select_n_o, .second_select_n_o);
  dual_bus_checker dual_bus_checker_i (.clk_i, .reset_i, .first_in_reset_i,
    .second_in_reset_i, .first_master_buffer_en_n_o, .second_master_buffer_en_n_o,
    .switch_closed_o, .first_space0_chip_enable_n(bus_if[0].space0_chip_enable_n),
    .first_master_read_strobe_n(bus_if[0].master_read_strobe_n),
    .first_master_write_strobe_n(bus_if[0].master_write_strobe_n),
    .first_master_output_enable_n(bus_if[0].master_output_enable_n),
    .first_master_addr_bit2(bus_if[0].master_addr_bit2),
    .first_bus_grant_ack_pin(bus_if[0].bus_grant_ack_pin),
    .first_access_ready(bus_if[0].access_ready),
    .second_space0_chip_enable_n(bus_if[1].space0_chip_enable_n),
    .second_hold_req(bus_if[1].hold_req), .second_bus_grant_ack(bus_if[1].bus_grant_ack),
    .second_slave_host_select_n(bus_if[1].slave_host_select_n),
    .second_slave_direction_in(bus_if[1].slave_direction_in),
    .second_slave_reg_select(bus_if[1].slave_reg_select),
    .second_access_ready(bus_if[1].access_ready),
    .first_page_hit(bus_if[0].master_addr_page == SECOND_PAGE_DEFAULT));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Slave write capture and grant watch
  always @(negedge clk_i) begin
    for (int p = 0; p < 2; p++) if (slave_wr[p] === 1'b1) got_wr[p] = slave_wr_data[p];
    if (bus_if[1].bus_grant_ack === 1'b1) saw_grant = 1'b1;
  end

  task automatic check(input logic [DATA_W-1:0] seen, exp, input string name);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One user access; returns read data in rd
  task automatic access(input int p, input logic wr, sel, input logic [DATA_W-1:0] wd);
    int n;
    for (n = 0; n < 200 && req_ready[p] !== 1'b1; n++) @(negedge clk_i);
    @(posedge clk_i);
    req_valid[p] <= 1'b1;
    req_write[p] <= wr;
    req_reg_sel[p] <= sel;
    req_page[p] <= (p == 0) ? SECOND_PAGE_DEFAULT : FIRST_PAGE_DEFAULT;
    req_wdata[p] <= wd;
    @(posedge clk_i);
    req_valid[p] <= 1'b0;
    for (n = 0; n < 200 && done[p] !== 1'b1; n++) @(negedge clk_i);
    check(32'(n < 200), 32'h1, "access completion");
    rd = rdata[p];
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #(40 * 5000);
    bad_count++;
    print_verdict();
  end

  initial begin
    {reset_i, first_in_reset_i, second_in_reset_i, saw_grant} = 4'hf;
    saw_grant = 1'b0;
    for (int p = 0; p < 2; p++) begin
      {req_valid[p], req_write[p], req_reg_sel[p], switch_close[p]} = 4'h0;
      req_page[p] = 4'h0;
      req_wdata[p] = 32'h0;
      got_wr[p] = 32'h0;
    end
    slave_rdata[0] = 32'h5a5a_0001;
    slave_rdata[1] = 32'ha5a5_0002;
    repeat (16) @(posedge clk_i);
    @(negedge clk_i);
    check(first_master_buffer_en_n_o, 32'h1, "first enable");
    check(second_master_buffer_en_n_o, 32'h1, "second enable");
    check({first_select_n_o, second_select_n_o}, 32'h3, "selects");
    check(switch_closed_o, 32'h0, "switch");
    @(posedge clk_i);
    {reset_i, first_in_reset_i, second_in_reset_i} <= 3'h0;
    @(negedge clk_i);
    check({cfg_ok[0], cfg_ok[1]}, 32'h3, "strap config");
    check({cfg_arb[0], cfg_arb[1]}, {ARB_ON, ARB_OFF}, "arbiter strap");
    @(posedge clk_i);
    switch_close[0] <= 1'b1;
    repeat (3) @(negedge clk_i);
    check(switch_closed_o, 32'h1, "switch");
    for (int p = 0; p < 2; p++) begin
      access(p, 1'b1, 1'b1, 32'h1234_5670 + p);
      check(got_wr[1 - p], 32'h1234_5670 + p, "slave data write");
      access(p, 1'b1, 1'b0, 32'h0000_0a40 + p);
      check(slave_addr[1 - p], 32'h0000_0a40 + p, "address register");
      access(p, 1'b0, 1'b0, 32'h0);
      check(rd, 32'h0000_0a40 + p, "address readback");
      access(p, 1'b0, 1'b1, 32'h0);
      check(rd, slave_rdata[1 - p], "data read");
    end
    check(saw_grant, 32'h1, "grant seen");
    @(posedge clk_i);
    second_in_reset_i <= 1'b1;
    repeat (2) @(negedge clk_i);
    check({first_master_buffer_en_n_o, second_master_buffer_en_n_o}, 32'h3, "enables");
    check(switch_closed_o, 32'h0, "switch in reset");
    @(posedge clk_i);
    second_in_reset_i <= 1'b0;
    access(0, 1'b1, 1'b1, 32'h0bad_cafe);
    check(got_wr[1], 32'h0bad_cafe, "write after reset");
    print_verdict();
  end
endmodule
